// ---- verilog/cmi_map.svh ----
// Constants for the connection memory loader and its host port.
// Assumes a 200 MHz aclk shared by both ends.
`ifndef CMI_MAP_SVH
`define CMI_MAP_SVH

// ****************************************
// Device register space (A14 low)
// ****************************************
`define CMI_CTRL_OFS 14'h0000
`define CMI_FILL_OFS 14'h0001
`define CMI_CTRL_MS_LSB 0
`define CMI_CTRL_MODE_BIT 4
`define CMI_FILL_START_BIT 0
`define CMI_FILL_LPAT_LSB 1
`define CMI_FILL_BPAT_LSB 4
`define CMI_MS_LCONN 3'h0
`define CMI_MS_BCONN 3'h1
`define CMI_MS_LDM 3'h2
`define CMI_MS_BDM 3'h3
`define CMI_SPACE_BIT 14
`define CMI_MEM_DEPTH 8192
`define CMI_LAST_IDX 13'h1fff

// ****************************************
// Timing
// ****************************************
`define CMI_CLK_MHZ 200
`define CMI_FILL_LIMIT_US 125
`define CMI_FILL_LIMIT_CYC (`CMI_FILL_LIMIT_US * `CMI_CLK_MHZ)
`define CMI_RST_HOLD_US 50
`define CMI_RST_HOLD_CYC (`CMI_RST_HOLD_US * `CMI_CLK_MHZ)
`define CMI_RST_CNT_W 14
`define CMI_GAP_NS 30
`define CMI_GAP_CYC ((`CMI_GAP_NS * `CMI_CLK_MHZ + 999) / 1000)

// ****************************************
// Host controller AXI4-Lite map
// ****************************************
`define CMI_H_CMD_OFS 4'h0
`define CMI_H_WDATA_OFS 4'h4
`define CMI_H_STATUS_OFS 4'h8
`define CMI_H_RDATA_OFS 4'hc
`define CMI_H_CMD_WR_BIT 16
`define CMI_H_ST_BUSY_BIT 0
`define CMI_H_ST_DONE_BIT 1

`endif

// ---- verilog/cmi_pkg.sv ----
// Types shared by the loader device and its host controller.
// Assumes cmi_map.svh for all numeric constants.
package cmi_pkg;
  typedef logic [15:0] cmi_word_t;
  typedef logic [14:0] cmi_addr_t;
  typedef logic [12:0] cmi_idx_t;
  typedef logic [31:0] cmi_lane_t;
  typedef logic [3:0] cmi_bufctl_t;
  typedef logic [31:0] cmi_axi_data_t;
  typedef logic [3:0] cmi_axi_addr_t;
  typedef enum {BS_IDLE, BS_ACK} cmi_dev_state_t;
  typedef enum {HS_IDLE, HS_STROBE, HS_RELEASE, HS_GAP} cmi_host_state_t;
endpackage

// ---- verilog/cmi_if.sv ----
// Parallel microprocessor bus between host controller and device.
// Assumes both ends clocked by the same aclk; data and acknowledge are resolved here.
`timescale 1ns/1ps
interface cmi_if;
  logic cs_n;
  logic ds_n;
  logic rd_wr_n;
  logic [14:0] addr;
  logic [15:0] host_d;
  logic host_d_oe;
  logic [15:0] dev_d;
  logic dev_d_oe;
  logic dev_ta_n;
  logic dev_ta_oe;
  logic [15:0] data;
  logic ta_n;

  // Undriven bus floats high
  assign data = dev_d_oe ? dev_d : (host_d_oe ? host_d : 16'hffff);
  assign ta_n = dev_ta_oe ? dev_ta_n : 1'b1;

  modport dev (input cs_n, ds_n, rd_wr_n, addr, data, output dev_d, dev_d_oe, dev_ta_n,
    dev_ta_oe);
  modport host (output cs_n, ds_n, rd_wr_n, addr, host_d, host_d_oe, input data, ta_n);
endinterface

// ---- verilog/cmi_dev.sv ----
// Switch-side end: connection memories, block fill, reset stretch, output forcing.
// Assumes a host on cmi_if.dev that holds strobes until acknowledge.
`timescale 1ns/1ps
`include "cmi_map.svh"

// Summary of operation
// RL1: Host sets mode bit before any fill
// RL2: Fill local words with pattern, zeros below
// RL3: Fill backplane words with pattern, zeros below
// RL4: Start bit self-clears within 125 us
// RL5: Clearing start or mode aborts fill
// RL6: Patterns reset to zero, default fill safe
// RL7: Default words source channel 0 stream 0
// RL8: Connection memories read/write, data memories read-only
// RL9: Acknowledge completes even without master clock
// RL10: Host leaves 30 ns between accesses
// RL11: Host initialises before enabling outputs
// RL12: Output disable forces buffers low, outputs safe
// RL13: Host holds reset at least two cycles
// RL14: Reset stretched 50 us after release
// RL15: Reset forces outputs and clears state
// RL16: Chip select ignored in reset, acknowledge answers
// RL17: A14 selects memory, stream and channel bits
// RL18: Word bits: source, message, tristate, address
// RL19: Both memories filled in parallel
module cmi_dev #(
  parameter int unsigned RST_HOLD_CYC = `CMI_RST_HOLD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  cmi_if.dev bus,
  input wire logic clock_present,
  input wire logic output_drive_enable,
  input wire logic local_output_reset_state,
  input wire logic backplane_output_reset_state,
  input wire cmi_pkg::cmi_lane_t local_stream_in,
  input wire cmi_pkg::cmi_lane_t backplane_stream_in,
  input wire logic dm_wr_en,
  input wire logic dm_wr_sel,
  input wire cmi_pkg::cmi_idx_t dm_wr_addr,
  input wire cmi_pkg::cmi_word_t dm_wr_data,
  output cmi_pkg::cmi_lane_t local_serial_out,
  output cmi_pkg::cmi_lane_t local_serial_oe,
  output cmi_pkg::cmi_lane_t backplane_serial_out,
  output cmi_pkg::cmi_lane_t backplane_serial_oe,
  output cmi_pkg::cmi_bufctl_t local_buffer_ctrl_out,
  output cmi_pkg::cmi_bufctl_t backplane_buffer_ctrl_out,
  output logic fill_busy
);
  import cmi_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  cmi_word_t local_conn_memory [`CMI_MEM_DEPTH];
  cmi_word_t backplane_conn_memory [`CMI_MEM_DEPTH];
  cmi_word_t local_data_memory [`CMI_MEM_DEPTH];
  cmi_word_t backplane_data_memory [`CMI_MEM_DEPTH];

  logic [`CMI_RST_CNT_W-1:0] rst_hold_r;
  logic rst_int;
  cmi_dev_state_t state_r;
  logic [2:0] mem_sel_r;
  logic block_program_mode_r;
  logic block_program_start_r;
  logic [2:0] local_fill_pattern_r;
  logic [2:0] backplane_fill_pattern_r;
  cmi_idx_t fill_idx_r;
  cmi_word_t rdata_r;
  logic ta_n_r;
  cmi_lane_t lst_r;
  cmi_lane_t bst_r;
  logic strobe;
  logic access;
  logic mem_space;
  logic mem_blocked;
  logic effective;
  logic reg_wr;
  logic mem_wr;
  cmi_idx_t idx;
  logic fill_last;
  logic out_force;

  // ****************************************
  // Reset stretch
  // ****************************************
  // Pin low acts at once on outputs; the counter then holds state in reset
  assign rst_int = !aresetn || (rst_hold_r != '0); // RL14
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_hold_r <= `CMI_RST_CNT_W'(RST_HOLD_CYC); // RL14
    end else if (rst_hold_r != '0) begin
      rst_hold_r <= rst_hold_r - `CMI_RST_CNT_W'(1);
    end
  end

  // ****************************************
  // Host port decode
  // ****************************************
  assign strobe = !bus.cs_n && !bus.ds_n;
  assign mem_space = bus.addr[`CMI_SPACE_BIT]; // RL17
  assign idx = bus.addr[12:0]; // RL17
  // Memory accesses wait while the fill owns the write ports
  assign mem_blocked = mem_space && fill_busy;
  assign access = (state_r == BS_IDLE) && strobe && !(mem_blocked && !rst_int && clock_present);
  // Without clock or in reset the cycle is acknowledged but has no effect
  assign effective = access && !rst_int && clock_present; // RL9 RL16
  assign reg_wr = effective && !bus.rd_wr_n && !mem_space;
  assign mem_wr = effective && !bus.rd_wr_n && mem_space;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= BS_IDLE;
    end else begin
      unique case (state_r)
        BS_IDLE: begin
          if (access) begin
            state_r <= BS_ACK; // RL9 RL16
          end
        end
        BS_ACK: begin
          if (!strobe) begin
            state_r <= BS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ta_n_r <= 1'b1;
    end else begin
      ta_n_r <= !(access || (state_r == BS_ACK && strobe));
    end
  end

  assign bus.dev_ta_n = ta_n_r;
  // Driven while selected or while acknowledge is still low, so it stays driven one cycle past deselect
  assign bus.dev_ta_oe = !bus.cs_n || !ta_n_r; // RL16
  assign bus.dev_d = rdata_r;
  assign bus.dev_d_oe = (state_r == BS_ACK) && bus.rd_wr_n && !bus.cs_n;

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge aclk) begin
    if (access && bus.rd_wr_n) begin
      if (!effective) begin
        rdata_r <= 16'h0000; // RL9
      end else if (mem_space) begin
        unique case (mem_sel_r)
          `CMI_MS_LCONN: rdata_r <= local_conn_memory[idx]; // RL8
          `CMI_MS_BCONN: rdata_r <= backplane_conn_memory[idx]; // RL8
          `CMI_MS_LDM: rdata_r <= local_data_memory[idx]; // RL8
          `CMI_MS_BDM: rdata_r <= backplane_data_memory[idx]; // RL8
          default: rdata_r <= 16'h0000;
        endcase
      end else if (bus.addr[13:0] == `CMI_CTRL_OFS) begin
        rdata_r <= {11'h000, block_program_mode_r, 1'b0, mem_sel_r};
      end else if (bus.addr[13:0] == `CMI_FILL_OFS) begin
        rdata_r <= {9'h000, backplane_fill_pattern_r, local_fill_pattern_r,
          block_program_start_r};
      end else begin
        rdata_r <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Control and block program registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (rst_int) begin
      mem_sel_r <= `CMI_MS_LCONN; // RL15
      block_program_mode_r <= 1'b0;
    end else if (reg_wr && bus.addr[13:0] == `CMI_CTRL_OFS) begin
      mem_sel_r <= bus.data[`CMI_CTRL_MS_LSB +: 3];
      block_program_mode_r <= bus.data[`CMI_CTRL_MODE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (rst_int) begin
      local_fill_pattern_r <= 3'h0; // RL6
      backplane_fill_pattern_r <= 3'h0; // RL6
    end else if (reg_wr && bus.addr[13:0] == `CMI_FILL_OFS) begin
      local_fill_pattern_r <= bus.data[`CMI_FILL_LPAT_LSB +: 3];
      backplane_fill_pattern_r <= bus.data[`CMI_FILL_BPAT_LSB +: 3];
    end
  end

  assign fill_busy = block_program_start_r && block_program_mode_r; // RL1 RL5
  assign fill_last = fill_idx_r == `CMI_LAST_IDX;

  always_ff @(posedge aclk) begin
    if (rst_int) begin
      block_program_start_r <= 1'b0;
    end else if (reg_wr && bus.addr[13:0] == `CMI_FILL_OFS) begin
      block_program_start_r <= bus.data[`CMI_FILL_START_BIT]; // RL5
    end else if (!block_program_mode_r) begin
      block_program_start_r <= 1'b0; // RL5 RL1
    end else if (fill_busy && fill_last) begin
      block_program_start_r <= 1'b0; // RL4
    end
  end

  // ****************************************
  // Fill engine
  // ****************************************
  // One word per cycle: 8192 cycles, about 41 us, well inside the limit
  always_ff @(posedge aclk) begin
    if (rst_int || !fill_busy) begin
      fill_idx_r <= '0; // RL5
    end else begin
      fill_idx_r <= fill_idx_r + 13'h0001; // RL19
    end
  end

  // Zero below the pattern selects stream 0 channel 0 in connection mode
  always_ff @(posedge aclk) begin
    if (fill_busy) begin
      local_conn_memory[fill_idx_r] <= {local_fill_pattern_r, 13'h0000}; // RL2 RL7 RL18 RL19
    end else if (mem_wr && mem_sel_r == `CMI_MS_LCONN) begin
      local_conn_memory[idx] <= bus.data; // RL8
    end
  end

  always_ff @(posedge aclk) begin
    if (fill_busy) begin
      backplane_conn_memory[fill_idx_r] <= {backplane_fill_pattern_r, 13'h0000}; // RL3 RL7 RL19
    end else if (mem_wr && mem_sel_r == `CMI_MS_BCONN) begin
      backplane_conn_memory[idx] <= bus.data; // RL8
    end
  end

  // Data memories take only switch-side captures, never host writes
  always_ff @(posedge aclk) begin
    if (dm_wr_en && !dm_wr_sel) begin
      local_data_memory[dm_wr_addr] <= dm_wr_data; // RL8
    end
  end

  always_ff @(posedge aclk) begin
    if (dm_wr_en && dm_wr_sel) begin
      backplane_data_memory[dm_wr_addr] <= dm_wr_data; // RL8
    end
  end

  // ****************************************
  // Serial outputs and buffer controls
  // ****************************************
  always_ff @(posedge aclk) begin
    if (rst_int) begin
      lst_r <= '1;
      bst_r <= '1;
    end else begin
      lst_r <= local_stream_in;
      bst_r <= backplane_stream_in;
    end
  end

  assign out_force = !output_drive_enable || rst_int; // RL12 RL15
  // Reset-state pin high drives ones; low floats the line
  assign local_serial_out = out_force ? '1 : lst_r; // RL12 RL15
  assign local_serial_oe = out_force ? {32{local_output_reset_state}} : '1; // RL12 RL15
  assign backplane_serial_out = out_force ? '1 : bst_r; // RL12 RL15
  assign backplane_serial_oe = out_force ? {32{backplane_output_reset_state}} : '1; // RL12
  assign local_buffer_ctrl_out = out_force ? 4'h0 : 4'hf; // RL12
  assign backplane_buffer_ctrl_out = out_force ? 4'h0 : 4'hf; // RL12
endmodule

// ---- verilog/cmi_host.sv ----
// Host-side end: AXI4-Lite command registers driving the parallel bus master.
// Assumes a device on cmi_if.host that acknowledges every strobe.
`timescale 1ns/1ps
`include "cmi_map.svh"

module cmi_host (
  input wire logic aclk,
  input wire logic aresetn,
  cmi_if.host bus,
  input wire cmi_pkg::cmi_axi_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire cmi_pkg::cmi_axi_data_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire cmi_pkg::cmi_axi_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output cmi_pkg::cmi_axi_data_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cmi_pkg::*;

  cmi_host_state_t state_r;
  logic aw_hold_r;
  logic w_hold_r;
  cmi_axi_addr_t awaddr_r;
  cmi_axi_data_t wbuf_r;
  cmi_addr_t cmd_addr_r;
  logic cmd_write_r;
  cmi_word_t cmd_wdata_r;
  cmi_word_t rdata_r;
  logic done_r;
  logic [2:0] gap_r;
  logic wr_fire;
  logic cmd_go;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;
  assign wr_fire = aw_hold_r && w_hold_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_r <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_r <= 1'b1;
        end
        if (s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_r <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wbuf_r <= s_axi_wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        `CMI_H_CMD_OFS: s_axi_rdata <= {15'h0000, cmd_write_r, 1'b0, cmd_addr_r};
        `CMI_H_WDATA_OFS: s_axi_rdata <= {16'h0000, cmd_wdata_r};
        `CMI_H_STATUS_OFS: s_axi_rdata <= {30'h00000000, done_r, state_r != HS_IDLE};
        `CMI_H_RDATA_OFS: s_axi_rdata <= {16'h0000, rdata_r};
        default: s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Command registers
  // ****************************************
  // A command written while busy is dropped; software polls status first
  assign cmd_go = wr_fire && awaddr_r == `CMI_H_CMD_OFS && state_r == HS_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_addr_r <= '0;
      cmd_write_r <= 1'b0;
      cmd_wdata_r <= '0;
    end else if (cmd_go) begin
      cmd_addr_r <= wbuf_r[14:0];
      cmd_write_r <= wbuf_r[`CMI_H_CMD_WR_BIT];
    end else if (wr_fire && awaddr_r == `CMI_H_WDATA_OFS && state_r == HS_IDLE) begin
      cmd_wdata_r <= wbuf_r[15:0];
    end
  end

  // ****************************************
  // Bus master
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= HS_IDLE;
      gap_r <= 3'h0;
    end else begin
      unique case (state_r)
        HS_IDLE: begin
          if (cmd_go) begin
            state_r <= HS_STROBE;
          end
        end
        HS_STROBE: begin
          if (!bus.ta_n) begin
            state_r <= HS_RELEASE;
          end
        end
        HS_RELEASE: begin
          if (bus.ta_n) begin
            state_r <= HS_GAP;
            gap_r <= 3'(`CMI_GAP_CYC); // RL10
          end
        end
        HS_GAP: begin
          gap_r <= gap_r - 3'h1;
          if (gap_r == 3'h1) begin
            state_r <= HS_IDLE; // RL10
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= '0;
      done_r <= 1'b0;
    end else if (cmd_go) begin
      done_r <= 1'b0;
    end else if (state_r == HS_STROBE && !bus.ta_n) begin
      done_r <= 1'b1;
      if (!cmd_write_r) begin
        rdata_r <= bus.data;
      end
    end
  end

  // Acknowledge is sampled while our own select is low, then watched for its release after select rises
  assign bus.cs_n = state_r != HS_STROBE; // RL16
  assign bus.ds_n = state_r != HS_STROBE;
  assign bus.rd_wr_n = !cmd_write_r;
  assign bus.addr = cmd_addr_r;
  assign bus.host_d = cmd_wdata_r;
  assign bus.host_d_oe = state_r == HS_STROBE && cmd_write_r;
endmodule

// ---- verification/cmi_bus_sva.sv ----
// Checker for the parallel bus joining host controller and loader.
// Assumes the interface signals on the shared aclk, sync low reset.
`timescale 1ns/1ps
module cmi_bus_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic ds_n,
  input wire logic rd_wr_n,
  input wire logic [14:0] addr,
  input wire logic host_d_oe,
  input wire logic dev_d_oe,
  input wire logic ta_n
);
  logic [13:0] wait_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // Stall counter
  // ****************************************
  // Memory access may wait out a whole fill
  always_ff @(posedge aclk) begin
    if (!aresetn || cs_n || !ta_n)
      wait_r <= 14'h0;
    else
      wait_r <= wait_r + 14'h1;
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_reg_ack; $fell(cs_n) && !addr[14] |=> !ta_n; endproperty
  property p_mem_wait; wait_r < 14'h206c; endproperty
  property p_ack_release; $rose(cs_n) |=> ta_n; endproperty
  property p_gap; $rose(ta_n) |-> (cs_n && ds_n) [*6]; endproperty
  property p_hold; !cs_n && ta_n |=> !cs_n && $stable(addr) && $stable(rd_wr_n); endproperty
  property p_read_drive; !cs_n && !ta_n && rd_wr_n |-> dev_d_oe; endproperty
  property p_quiet; cs_n |-> !dev_d_oe; endproperty
  property p_wr_drive; !cs_n && !rd_wr_n |-> host_d_oe && !dev_d_oe; endproperty
  property p_ta_gate; cs_n && $past(cs_n) |-> ta_n; endproperty
  property p_same; cs_n == ds_n; endproperty
  a_reg_ack: assert property (p_reg_ack) else $error("register access not acknowledged");
  a_mem_wait: assert property (p_mem_wait) else $error("memory access stalled too long");
  a_ack_release: assert property (p_ack_release) else $error("acknowledge held");
  a_gap: assert property (p_gap) else $error("next access too soon");
  a_hold: assert property (p_hold) else $error("request changed before ack");
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");
  a_quiet: assert property (p_quiet) else $error("data driven while deselected");
  a_wr_drive: assert property (p_wr_drive) else $error("write data drive wrong");
  a_ta_gate: assert property (p_ta_gate) else $error("acknowledge while deselected");
  a_same: assert property (p_same) else $error("strobes split");
  c_mem: cover property ($fell(cs_n) && addr[14]);
  c_read: cover property (!ta_n && rd_wr_n);
  c_release: cover property ($rose(ta_n));
endmodule

// ---- verification/connection_memory_init_and_reset_test.sv ----
// Self-checking bench: host controller and loader joined over cmi_if.
// Assumes AXI4-Lite command map of the host and a shortened reset stretch.
`timescale 1ns/1ps
module connection_memory_init_and_reset_test;
  import cmi_pkg::*;
  logic aclk = 1'b0;
  logic aresetn, clock_present, out_en, lrs, brs, dm_wr_en, dm_wr_sel, fill_busy;
  cmi_lane_t lin, bin, lso, lsoe, bso, bsoe;
  cmi_idx_t dm_wr_addr;
  cmi_word_t dm_wr_data;
  cmi_bufctl_t lbc, bbc;
  cmi_axi_addr_t awaddr, araddr;
  cmi_axi_data_t wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  cmi_word_t exp_q[$];
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  always #2.5 aclk = ~aclk;
  cmi_if u_cmi_if();
  cmi_dev #(.RST_HOLD_CYC(300)) u_cmi_dev (.aclk(aclk), .aresetn(aresetn), .bus(u_cmi_if),
    .clock_present(clock_present), .output_drive_enable(out_en), .local_output_reset_state(lrs),
    .backplane_output_reset_state(brs), .local_stream_in(lin), .backplane_stream_in(bin),
    .dm_wr_en(dm_wr_en), .dm_wr_sel(dm_wr_sel), .dm_wr_addr(dm_wr_addr),
    .dm_wr_data(dm_wr_data), .local_serial_out(lso), .local_serial_oe(lsoe),
    .backplane_serial_out(bso), .backplane_serial_oe(bsoe), .local_buffer_ctrl_out(lbc),
    .backplane_buffer_ctrl_out(bbc), .fill_busy(fill_busy));
  cmi_host u_cmi_host (.aclk(aclk), .aresetn(aresetn), .bus(u_cmi_if), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  cmi_bus_sva u_cmi_bus_sva (.aclk(aclk), .aresetn(aresetn), .cs_n(u_cmi_if.cs_n),
    .ds_n(u_cmi_if.ds_n), .rd_wr_n(u_cmi_if.rd_wr_n), .addr(u_cmi_if.addr),
    .host_d_oe(u_cmi_if.host_d_oe), .dev_d_oe(u_cmi_if.dev_d_oe), .ta_n(u_cmi_if.ta_n));
  // ****************************************
  // Checking and ending
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d of %0d checks", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0)
      chk({16'h0, rdata[15:0]}, {16'h0, exp_q.pop_front()});
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      conclude();
    end
  end
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic axi_wr(input cmi_axi_addr_t a, input cmi_axi_data_t d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, 32'h0);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input cmi_axi_addr_t a, input bit note, input cmi_word_t e,
      output cmi_axi_data_t d);
    @(posedge aclk);
    if (note) exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    chk({30'h0, rresp}, 32'h0);
    rready <= 1'b0;
  endtask
  task automatic dev_acc(input cmi_addr_t a, input logic wr, input cmi_word_t d);
    cmi_axi_data_t st;
    axi_wr(4'h4, {16'h0, d});
    axi_wr(4'h0, {15'h0, wr, 1'b0, a});
    do axi_rd(4'h8, 1'b0, 16'h0, st); while (st[0] !== 1'b0);
  endtask
  task automatic dev_rd(input cmi_addr_t a, input cmi_word_t e);
    cmi_axi_data_t st;
    dev_acc(a, 1'b0, 16'h0);
    axi_rd(4'hc, 1'b1, e, st);
  endtask
  function automatic cmi_addr_t mem(input cmi_idx_t i);
    return {2'b10, i};
  endfunction
  task automatic run_fill(input logic [2:0] lp, input logic [2:0] bp);
    int n;
    cmi_idx_t i;
    n = 0;
    i = cmi_idx_t'($urandom);
    dev_acc(15'h0001, 1'b1, {9'h0, bp, lp, 1'b1});
    chk({31'h0, fill_busy}, 32'h1);
    while (fill_busy !== 1'b0) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, n < 25000}, 32'h1);
    dev_rd(15'h0001, {9'h0, bp, lp, 1'b0});
    dev_acc(15'h0000, 1'b1, 16'h0010);
    dev_rd(mem(13'h0), {lp, 13'h0});
    dev_rd(mem(i), {lp, 13'h0});
    dev_acc(15'h0000, 1'b1, 16'h0011);
    dev_rd(mem(13'h1fff), {bp, 13'h0});
    dev_rd(mem(i), {bp, 13'h0});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cmi_idx_t i;
    cmi_word_t v;
    void'($urandom(11490));
    {aresetn, clock_present, out_en, lrs, brs, dm_wr_en, dm_wr_sel} = 7'b0101000;
    {lin, bin, dm_wr_addr, dm_wr_data} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (5) @(posedge aclk);
    chk({28'h0, lbc}, 32'h0);
    chk(lso, 32'hffffffff);
    chk(lsoe, 32'hffffffff);
    chk(bsoe, 32'h0);
    aresetn <= 1'b1;
    dev_acc(15'h0001, 1'b1, 16'h007e);
    dev_rd(15'h0001, 16'h0000);
    chk({28'h0, bbc}, 32'h0);
    repeat (300) @(posedge aclk);
    dev_rd(15'h0001, 16'h0000);
    dev_rd(15'h0000, 16'h0000);
    dev_acc(15'h0001, 1'b1, 16'h0001);
    dev_rd(15'h0001, 16'h0000);
    dev_acc(15'h0000, 1'b1, 16'h0010);
    run_fill(3'h0, 3'h0);
    lin <= $urandom;
    bin <= $urandom;
    repeat (2) @(posedge aclk);
    chk({24'h0, lbc, bbc}, 32'h0);
    chk(lso, 32'hffffffff);
    chk(bsoe, 32'h0);
    // Outputs come up only once both memories hold safe words
    out_en <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({24'h0, lbc, bbc}, 32'hff);
    chk(lso, lin);
    chk(bso, bin);
    chk(bsoe, 32'hffffffff);
    run_fill(3'($urandom), 3'($urandom));
    // Memory read issued mid-fill stalls until the fill is done
    dev_acc(15'h0001, 1'b1, 16'h0051);
    dev_rd(mem(13'h0), 16'ha000);
    for (int s = 0; s < 4; s++) begin
      i = cmi_idx_t'($urandom);
      v = cmi_word_t'($urandom);
      dm_wr_sel <= s[0];
      dm_wr_addr <= i;
      dm_wr_data <= v;
      dm_wr_en <= (s > 1);
      @(posedge aclk);
      dm_wr_en <= 1'b0;
      dev_acc(15'h0000, 1'b1, 16'h0010 | 16'(s));
      dev_acc(mem(i), 1'b1, (s > 1) ? ~v : v);
      dev_rd(mem(i), v);
    end
    for (int k = 0; k < 2; k++) begin
      dev_acc(15'h0000, 1'b1, 16'h0010);
      dev_acc(mem(13'h1fff), 1'b1, 16'h1234);
      dev_acc(15'h0001, 1'b1, 16'h007f);
      dev_acc(k[14:0], 1'b1, (k == 0) ? 16'h0000 : 16'h007e);
      chk({31'h0, fill_busy}, 32'h0);
      dev_rd(15'h0001, 16'h007e);
      dev_acc(15'h0000, 1'b1, 16'h0010);
      dev_rd(mem(13'h1fff), 16'h1234);
    end
    clock_present <= 1'b0;
    dev_acc(15'h0001, 1'b1, 16'h0001);
    dev_rd(15'h0001, 16'h0000);
    clock_present <= 1'b1;
    dev_rd(15'h0001, 16'h007e);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    chk(bsoe, 32'h0);
    aresetn <= 1'b1;
    repeat (310) @(posedge aclk);
    dev_rd(15'h0001, 16'h0000);
    repeat (2) @(posedge aclk);
    conclude();
  end
endmodule
